/* File: rtl/prcg_map.vh */
// register map, field positions and reset values of the reset/clock gate unit
`ifndef PRCG_MAP_VH
`define PRCG_MAP_VH

// register byte offsets
`define PRCG_HS_RESET_OFS 8'h0C
`define PRCG_LS_RESET_OFS 8'h10
`define PRCG_HSBUS_CLKEN_OFS 8'h14
`define PRCG_HSPER_CLKEN_OFS 8'h18

// reset values
`define PRCG_HS_RESET_RST 32'h00000000
`define PRCG_LS_RESET_RST 32'h00000000
`define PRCG_HSBUS_CLKEN_RST 32'h00000014
`define PRCG_HSPER_CLKEN_RST 32'h00000000

// writable bit masks
`define PRCG_HS_RESET_MASK 32'h00000001
`define PRCG_LS_RESET_MASK 32'h38664831
`define PRCG_HSBUS_CLKEN_MASK 32'h007E405F
`define PRCG_HSPER_CLKEN_MASK 32'hFFFFFFFF

// hs reset field
`define PRCG_SYSCFG_RST_BIT 0
// ls reset fields
`define PRCG_DAC_RST_BIT 29
`define PRCG_PWR_RST_BIT 28
`define PRCG_BKP_RST_BIT 27
`define PRCG_I2C2_RST_BIT 22
`define PRCG_I2C1_RST_BIT 21
`define PRCG_USART3_RST_BIT 18
`define PRCG_USART2_RST_BIT 17
`define PRCG_SPI2_RST_BIT 14
`define PRCG_WDG_RST_BIT 11
`define PRCG_TIM6_RST_BIT 5
`define PRCG_TIM5_RST_BIT 4
`define PRCG_TIM1_RST_BIT 0
// hs bus clock fields
`define PRCG_GPIO_LO_BIT 17
`define PRCG_GPIO_COUNT 6
`define PRCG_MFCOMM_BIT 14
`define PRCG_CHKSUM_BIT 6
`define PRCG_FLASH_SLP_BIT 4
`define PRCG_DMAMUX_BIT 3
`define PRCG_RAM_SLP_BIT 2
`define PRCG_DMA2_BIT 1
`define PRCG_DMA1_BIT 0

`endif

/* File: rtl/prcg_apb_regs.v */
// apb slave holding the four control registers
`timescale 1ns/1ns
`include "prcg_map.vh"
module prcg_apb_regs (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output reg [31:0] hs_reset_reg,
    output reg [31:0] ls_reset_reg,
    output reg [31:0] hsbus_clken_reg,
    output reg [31:0] hsper_clken_reg
);
    // decode of the current address
    wire hit_hsr = (paddr == `PRCG_HS_RESET_OFS);
    wire hit_lsr = (paddr == `PRCG_LS_RESET_OFS);
    wire hit_hbc = (paddr == `PRCG_HSBUS_CLKEN_OFS);
    wire hit_hpc = (paddr == `PRCG_HSPER_CLKEN_OFS);
    wire hit_any = hit_hsr | hit_lsr | hit_hbc | hit_hpc;
    wire access = psel & penable;
    wire wr = access & pwrite;

    // zero-wait slave; unmapped address errors
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;

    // register writes, reserved bits forced to reset value
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hs_reset_reg <= `PRCG_HS_RESET_RST;
            ls_reset_reg <= `PRCG_LS_RESET_RST;
            hsbus_clken_reg <= `PRCG_HSBUS_CLKEN_RST;
            hsper_clken_reg <= `PRCG_HSPER_CLKEN_RST;
        end else if (wr) begin
            if (hit_hsr)
                hs_reset_reg <= pwdata & `PRCG_HS_RESET_MASK;
            if (hit_lsr)
                ls_reset_reg <= pwdata & `PRCG_LS_RESET_MASK;
            if (hit_hbc)
                hsbus_clken_reg <= (pwdata & `PRCG_HSBUS_CLKEN_MASK);
            if (hit_hpc)
                hsper_clken_reg <= pwdata & `PRCG_HSPER_CLKEN_MASK;
        end
    end

    // read data registered in the setup phase
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            if (hit_hsr)
                prdata <= hs_reset_reg;
            else if (hit_lsr)
                prdata <= ls_reset_reg;
            else if (hit_hbc)
                prdata <= hsbus_clken_reg;
            else if (hit_hpc)
                prdata <= hsper_clken_reg;
            else
                prdata <= 32'h00000000;
        end
    end
endmodule

/* File: rtl/prcg_clk_gate.v */
// flop-based glitch-free clock gate, enable taken while clock low
`timescale 1ns/1ns
module prcg_clk_gate (
    input wire ref_clk,
    input wire rstn,
    input wire enable,
    output wire gated_clk
);
    // enable sampled on falling edge, stable while clock high
    reg en_reg;
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en_reg <= 1'b0;
        end else begin
            en_reg <= enable;
        end
    end
    assign gated_clk = ref_clk & en_reg;
endmodule

/* File: rtl/prcg_top.v */
// top of the peripheral reset and clock gate control unit
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "prcg_map.vh"
module prcg_top (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    input wire sleep_mode,
    output reg sysconfig_reset_hold,
    output reg dac_reset_hold,
    output reg power_ctrl_reset_hold,
    output reg backup_ctrl_reset_hold,
    output reg second_i2c_reset_hold,
    output reg first_i2c_reset_hold,
    output reg third_usart_reset_hold,
    output reg second_usart_reset_hold,
    output reg second_spi_reset_hold,
    output reg window_watchdog_reset_hold,
    output reg timer_six_reset_hold,
    output reg timer_five_reset_hold,
    output reg timer_one_reset_hold,
    output wire [5:0] gpio_clk,
    output wire multifunc_comm_clk,
    output wire checksum_unit_clk,
    output wire dma_request_mux_clk,
    output wire second_dma_clk,
    output wire first_dma_clk,
    output wire flash_ctrl_clk,
    output wire ram_if_clk,
    output wire [31:0] hsper_clk
);
    // register contents
    wire [31:0] hs_reset_reg;
    wire [31:0] ls_reset_reg;
    wire [31:0] hsbus_clken_reg;
    wire [31:0] hsper_clken_reg;

    // apb register block
    prcg_apb_regs u_regs (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .hs_reset_reg(hs_reset_reg),
        .ls_reset_reg(ls_reset_reg),
        .hsbus_clken_reg(hsbus_clken_reg),
        .hsper_clken_reg(hsper_clken_reg)
    );

    // reset holds registered one cycle after the register bit
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sysconfig_reset_hold <= 1'b0;
            dac_reset_hold <= 1'b0;
            power_ctrl_reset_hold <= 1'b0;
            backup_ctrl_reset_hold <= 1'b0;
            second_i2c_reset_hold <= 1'b0;
            first_i2c_reset_hold <= 1'b0;
            third_usart_reset_hold <= 1'b0;
            second_usart_reset_hold <= 1'b0;
            second_spi_reset_hold <= 1'b0;
            window_watchdog_reset_hold <= 1'b0;
            timer_six_reset_hold <= 1'b0;
            timer_five_reset_hold <= 1'b0;
            timer_one_reset_hold <= 1'b0;
        end else begin
            sysconfig_reset_hold <= hs_reset_reg[`PRCG_SYSCFG_RST_BIT];
            dac_reset_hold <= ls_reset_reg[`PRCG_DAC_RST_BIT];
            power_ctrl_reset_hold <= ls_reset_reg[`PRCG_PWR_RST_BIT];
            backup_ctrl_reset_hold <= ls_reset_reg[`PRCG_BKP_RST_BIT];
            second_i2c_reset_hold <= ls_reset_reg[`PRCG_I2C2_RST_BIT];
            first_i2c_reset_hold <= ls_reset_reg[`PRCG_I2C1_RST_BIT];
            third_usart_reset_hold <= ls_reset_reg[`PRCG_USART3_RST_BIT];
            second_usart_reset_hold <= ls_reset_reg[`PRCG_USART2_RST_BIT];
            second_spi_reset_hold <= ls_reset_reg[`PRCG_SPI2_RST_BIT];
            window_watchdog_reset_hold <= ls_reset_reg[`PRCG_WDG_RST_BIT];
            timer_six_reset_hold <= ls_reset_reg[`PRCG_TIM6_RST_BIT];
            timer_five_reset_hold <= ls_reset_reg[`PRCG_TIM5_RST_BIT];
            timer_one_reset_hold <= ls_reset_reg[`PRCG_TIM1_RST_BIT];
        end
    end

    // sleep-aware enables for flash and ram
    // flash clock kept in sleep only if set
    wire flash_en = ~sleep_mode | hsbus_clken_reg[`PRCG_FLASH_SLP_BIT];
    // ram clock kept in sleep only if set
    wire ram_en = ~sleep_mode | hsbus_clken_reg[`PRCG_RAM_SLP_BIT];

    // gpio port gates, a at bit 17 up to f at bit 22
    genvar gi;
    generate
        for (gi = 0; gi < `PRCG_GPIO_COUNT; gi = gi + 1) begin : g_gpio
            prcg_clk_gate u_gate (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .enable(hsbus_clken_reg[`PRCG_GPIO_LO_BIT + gi]),
                .gated_clk(gpio_clk[gi])
            );
        end
        // high-speed peripheral clock gates
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_hsper
            // peripheral clock gate, off after reset
            prcg_clk_gate u_gate (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .enable(hsper_clken_reg[gi]),
                .gated_clk(hsper_clk[gi])
            );
        end
    endgenerate

    prcg_clk_gate u_mfcomm (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(hsbus_clken_reg[`PRCG_MFCOMM_BIT]),
        .gated_clk(multifunc_comm_clk)
    );
    prcg_clk_gate u_chksum (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(hsbus_clken_reg[`PRCG_CHKSUM_BIT]),
        .gated_clk(checksum_unit_clk)
    );
    prcg_clk_gate u_dmamux (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(hsbus_clken_reg[`PRCG_DMAMUX_BIT]),
        .gated_clk(dma_request_mux_clk)
    );
    prcg_clk_gate u_dma2 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(hsbus_clken_reg[`PRCG_DMA2_BIT]),
        .gated_clk(second_dma_clk)
    );
    prcg_clk_gate u_dma1 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(hsbus_clken_reg[`PRCG_DMA1_BIT]),
        .gated_clk(first_dma_clk)
    );
    prcg_clk_gate u_flash (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(flash_en),
        .gated_clk(flash_ctrl_clk)
    );
    prcg_clk_gate u_ram (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(ram_en),
        .gated_clk(ram_if_clk)
    );
endmodule

/* File: verif/prcg_top_chk.sv */
// pin-level checker of the reset and clock gate unit
`timescale 1ns/1ns
module prcg_chk (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire sleep_mode,
    input wire sysconfig_reset_hold,
    input wire dac_reset_hold,
    input wire second_i2c_reset_hold,
    input wire timer_one_reset_hold,
    input wire [5:0] gpio_clk,
    input wire flash_ctrl_clk
);
    // short clock and reset names
    wire c = ref_clk;
    wire r = rstn;
    // access phase and address decode
    wire acc = psel && penable;
    wire bad = !(paddr == 8'h0C || paddr == 8'h10 || paddr == 8'h14
        || paddr == 8'h18);
    // software writes to the two reset registers
    sequence hs_wr;
        acc && pwrite && paddr == 8'h0C;
    endsequence
    sequence ls_wr;
        acc && pwrite && paddr == 8'h10;
    endsequence
    syscfg_hold_a: assert property (@(posedge c) disable iff (!r)
        hs_wr |-> ##2 sysconfig_reset_hold == $past(pwdata[0], 2))
        else $error("sysconfig hold wrong");
    dac_hold_a: assert property (@(posedge c) disable iff (!r)
        ls_wr |-> ##2 dac_reset_hold == $past(pwdata[29], 2))
        else $error("dac hold wrong");
    i2c_steady_a: assert property (@(posedge c) disable iff (!r)
        $changed(second_i2c_reset_hold) |->
        $past(acc && pwrite && paddr == 8'h10, 2))
        else $error("i2c hold moved without write");
    timer_hold_a: assert property (@(posedge c) disable iff (!r)
        ls_wr |-> ##2 timer_one_reset_hold == $past(pwdata[0], 2))
        else $error("timer one hold wrong");
    gpio_gate_a: assert property (@(negedge c) disable iff (!r)
        (acc && pwrite && paddr == 8'h14) |-> ##2
        gpio_clk[0] == $past(pwdata[17], 2))
        else $error("gpio a clock gate wrong");
    flash_awake_a: assert property (@(negedge c) disable iff (!r)
        ($past(rstn) && !sleep_mode && !$past(sleep_mode)) |->
        flash_ctrl_clk) else $error("flash clock stopped while awake");
    slverr_map_a: assert property (@(posedge c) disable iff (!r)
        acc |-> pslverr == bad) else $error("error response wrong");
    bad_read_a: assert property (@(posedge c) disable iff (!r)
        acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind prcg_top prcg_chk chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .sysconfig_reset_hold(sysconfig_reset_hold),
    .dac_reset_hold(dac_reset_hold),
    .second_i2c_reset_hold(second_i2c_reset_hold),
    .timer_one_reset_hold(timer_one_reset_hold), .gpio_clk(gpio_clk),
    .flash_ctrl_clk(flash_ctrl_clk));

/* File: verif/prcg_top_tb.sv */
// self-checking bench of the reset and clock gate unit
`timescale 1ns/1ns
module prcg_top_tb;
    reg ref_clk = 1'b0;
    reg rstn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg sleep_mode = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    wire pready;
    wire pslverr;
    wire [31:0] prdata;
    wire [31:0] hsper_clk;
    wire [12:0] hold; // reset holds, sysconfig on top
    wire [12:0] gv; // gpio f..a, comm, crc, mux, dma2, dma1, flash, ram
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer j;
    reg [31:0] rd;
    reg err;
    prcg_top uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .sysconfig_reset_hold(hold[12]),
        .dac_reset_hold(hold[11]), .power_ctrl_reset_hold(hold[10]),
        .backup_ctrl_reset_hold(hold[9]), .second_i2c_reset_hold(hold[8]),
        .first_i2c_reset_hold(hold[7]), .third_usart_reset_hold(hold[6]),
        .second_usart_reset_hold(hold[5]), .second_spi_reset_hold(hold[4]),
        .window_watchdog_reset_hold(hold[3]),
        .timer_six_reset_hold(hold[2]), .timer_five_reset_hold(hold[1]),
        .timer_one_reset_hold(hold[0]), .gpio_clk(gv[12:7]),
        .multifunc_comm_clk(gv[6]), .checksum_unit_clk(gv[5]),
        .dma_request_mux_clk(gv[4]), .second_dma_clk(gv[3]),
        .first_dma_clk(gv[2]), .flash_ctrl_clk(gv[1]),
        .ram_if_clk(gv[0]), .hsper_clk(hsper_clk));
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // verdict and end of run
    task complete_run;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // compare one value
    task cmp(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // one apb transfer, bounded wait for pready
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt = error_cnt + 1;
            complete_run;
        end else begin
            // answer taken at the access edge, then released
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // wait edges, then let updates land
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // reset values of all four registers
    task t_reset;
        for (j = 0; j < 4; j = j + 1) begin
            apb(1'b0, 8'h0C + 8'(4 * j), 32'h0);
            cmp(rd, j == 2 ? 32'h14 : 32'h0);
        end
        cmp(hold, 13'h0);
        tick(1);
        cmp(gv, 13'h3);
        $display("test reset values done");
    endtask
    // each low-speed hold bit alone, then all hold bits together
    task t_holds;
        integer p [0:11];
        p = '{29, 28, 27, 22, 21, 18, 17, 14, 11, 5, 4, 0};
        for (j = 0; j < 12; j = j + 1) begin
            apb(1'b1, 8'h10, 32'h1 << p[j]);
            tick(1);
            cmp(hold, 13'h1 << (11 - j));
        end
        // every hold bit set, reserved bits kept at zero
        apb(1'b1, 8'h10, 32'h38664831);
        apb(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h38664831);
        apb(1'b1, 8'h0C, 32'h1);
        tick(1);
        cmp(hold, 13'h1FFF);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h10, 32'h0);
        tick(1);
        cmp(hold, 13'h0);
        $display("test reset holds done");
    endtask
    // each bus clock gate alone, asleep, then awake
    task t_gates;
        integer p [0:12];
        p = '{22, 21, 20, 19, 18, 17, 14, 6, 3, 1, 0, 4, 2};
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        for (j = 0; j < 13; j = j + 1) begin
            apb(1'b1, 8'h14, 32'h1 << p[j]);
            tick(2);
            cmp(gv, 13'h1 << (12 - j));
        end
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        apb(1'b1, 8'h14, 32'h0);
        tick(2);
        cmp(gv, 13'h3);
        apb(1'b1, 8'h18, 32'hA5C30F96);
        tick(2);
        cmp(hsper_clk, 32'hA5C30F96);
        $display("test clock gates done");
    endtask
    // unmapped place refuses and reads zero
    task t_bad;
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        cmp({31'h0, err}, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        cmp({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 8'h10, 32'h0);
        cmp({err, rd[30:0]}, 32'h0);
        $display("test unmapped access done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset;
        t_holds;
        t_gates;
        t_bad;
        complete_run;
    end
endmodule
